// >>> src/dtc_pkg.sv
// package: register map, field layout and types for the sync/blank timing block
`default_nettype none
package dtc_pkg;
  localparam int unsigned DTC_IDX_W      = 5;
  localparam logic [4:0] DTC_IDX_HTOTAL  = 5'h00;
  localparam logic [4:0] DTC_IDX_HDEND   = 5'h01;
  localparam logic [4:0] DTC_IDX_HBSTART = 5'h02;
  localparam logic [4:0] DTC_IDX_HBEND   = 5'h03;
  localparam logic [4:0] DTC_IDX_HRSTART = 5'h04;
  localparam logic [4:0] DTC_IDX_HREND   = 5'h05;
  localparam logic [4:0] DTC_IDX_VTOTAL  = 5'h06;
  localparam logic [4:0] DTC_IDX_VHIGH   = 5'h07;
  localparam logic [4:0] DTC_IDX_PRESET  = 5'h08;
  localparam logic [4:0] DTC_IDX_MAXSCAN = 5'h09;
  localparam logic [4:0] DTC_IDX_VRSTART = 5'h10;
  localparam logic [4:0] DTC_IDX_VDEND   = 5'h12;
  localparam logic [4:0] DTC_IDX_VBSTART = 5'h15;
  localparam logic [4:0] DTC_IDX_LCMP    = 5'h18;
  // port addresses, low nibble selects index or data
  localparam logic [15:0] DTC_PORT_MONO_IDX  = 16'h03b4;
  localparam logic [15:0] DTC_PORT_MONO_DAT  = 16'h03b5;
  localparam logic [15:0] DTC_PORT_COLOR_IDX = 16'h03d4;
  localparam logic [15:0] DTC_PORT_COLOR_DAT = 16'h03d5;
  // reset values are plain choices that give a usable line at power-up
  localparam logic [7:0] DTC_RST_HBEND   = 8'h80;
  localparam logic [7:0] DTC_RST_ZERO    = 8'h00;
  localparam logic [7:0] DTC_RST_HTOTAL  = 8'h5f;
  localparam logic [7:0] DTC_RST_HDEND   = 8'h4f;
  localparam logic [7:0] DTC_RST_HBSTART = 8'h50;
  localparam logic [7:0] DTC_RST_HRSTART = 8'h55;
  localparam logic [7:0] DTC_RST_HREND   = 8'h81;
  localparam logic [7:0] DTC_RST_VTOTAL  = 8'hbf;
  localparam logic [7:0] DTC_RST_VHIGH   = 8'h1f;
  localparam logic [7:0] DTC_RST_MAXSCAN = 8'h0f;
  localparam logic [7:0] DTC_IDX_MASK    = 8'h1f;
  localparam int unsigned DTC_HTOTAL_ADD = 5;
  localparam int unsigned DTC_VTOTAL_ADD = 2;
  localparam int unsigned DTC_SKEW_MAX   = 3;
  localparam int unsigned DTC_NREG       = 32;

  typedef struct packed {
    logic [7:0] htotal, hdend, hbstart, hbend, hrstart, hrend;
    logic [7:0] vtotal, vhigh, preset, maxscan;
  } dtc_regs_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } dtc_bus_t;

  typedef struct packed {
    logic hblank;
    logic hretrace;
    logic vretrace;
    logic disp_en;
  } dtc_video_t;

  typedef struct packed {
    logic [4:0] row_scan;
    logic [1:0] byte_pan;
    logic [9:0] line;
  } dtc_scan_t;

  function automatic logic [9:0] dtc_vtotal(input dtc_regs_t r);
    return {r.vhigh[5], r.vhigh[0], r.vtotal};
  endfunction
  function automatic logic [5:0] dtc_hb_end(input dtc_regs_t r);
    return {r.hrend[7], r.hbend[4:0]};
  endfunction
endpackage
`default_nettype wire

// >>> src/dtc_skew.sv
// delay line of 0..3 character clocks for one timing signal
`default_nettype none
module dtc_skew (
  input  wire logic       i_clock,
  input  wire logic       i_rst_n,
  input  wire logic       i_sig,
  input  wire logic [1:0] i_sel,
  output logic            o_sig
);
  import dtc_pkg::*;
  typedef struct packed {
    logic [DTC_SKEW_MAX-1:0] tap;
  } dtc_skew_st_t;
  dtc_skew_st_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.tap = {s_q.tap[DTC_SKEW_MAX-2:0], i_sig};
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // zero skew passes the input straight; callers register it afterwards
  always_comb begin
    unique case (i_sel)
      2'h0: o_sig = i_sig;
      2'h1: o_sig = s_q.tap[0];
      2'h2: o_sig = s_q.tap[1];
      2'h3: o_sig = s_q.tap[2];
    endcase
  end
endmodule
`default_nettype wire

// >>> src/dtc_timing.sv
// sync, blanking and row scan timing with index/data register ports
//
// Summary of operation
// R1 - software writes end-blank bit 7 as one; it is stored and read back
// R2 - display enable delayed 0..3 character clocks by end-blank bits 6:5
// R3 - blanking goes low when counter low six bits equal end-blank value
// R4 - end-blank value is index 03 bits 4:0 plus index 05 bit 7
// R5 - software sets end-blank to start plus width, six bits
// R6 - retrace goes active when counter equals start-retrace register
// R7 - retrace goes low when counter low five bits equal end-retrace 4:0
// R8 - retrace output skewed by end-retrace bits 6:5, 00 no delay
// R9 - software sets end-retrace to start plus width, five bits
// R10 - vertical total is ten bits, lines minus two, sets frame period
// R11 - high-bits register feeds bit 8/9 of vertical fields
// R12 - row scan loads preset bits 4:0 after each vertical retrace
// R13 - row scan steps per line, clears to zero at maximum row scan
// R14 - preset bits 6:5 extend pixel panning in multiple shift modes
// R15 - software bumps start address past the panning range
// R16 - each register read and written through data port by index
// R17 - index uses bits 4:0, port base follows colour select
// R18 - blanking goes active when counter reaches start-blank register
// R19 - line length is horizontal total plus five characters
// R20 - comparisons once per character clock, outputs registered
`default_nettype none
module dtc_timing (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_color_sel,
  input  wire dtc_pkg::dtc_bus_t i_bus,
  output logic [7:0]             o_rdata,
  output logic                   o_rvalid,
  output dtc_pkg::dtc_video_t    o_video,
  output dtc_pkg::dtc_scan_t     o_scan
);
  import dtc_pkg::*;

  typedef struct packed {
    dtc_regs_t  regs;
    logic [4:0] index;
    logic [7:0] hcount;
    logic [9:0] vcount;
    logic       hblank;
    logic       hretr;
    logic       vretr;
    logic       de_raw;
    logic [4:0] row;
    logic [7:0] rdata;
    logic       rvalid;
    dtc_video_t video;
  } dtc_state_t;

  dtc_state_t s_q, s_d;
  logic       de_skewed;
  logic       hr_skewed;
  logic       idx_hit;
  logic       dat_hit;
  logic       line_end;
  logic       frame_end;
  logic [7:0] htotal_ext;
  logic [9:0] vtot;

  // one comparator shape for both ports keeps their decode in step
  function automatic logic port_match(input logic [15:0] addr,
                                      input logic        color,
                                      input logic [15:0] mono,
                                      input logic [15:0] colr);
    return addr == (color ? colr : mono);
  endfunction

  // port base follows the colour select from the miscellaneous output
  always_comb begin
    idx_hit = port_match(i_bus.addr, i_color_sel, DTC_PORT_MONO_IDX,
                         DTC_PORT_COLOR_IDX); // [R17]
    dat_hit = port_match(i_bus.addr, i_color_sel, DTC_PORT_MONO_DAT,
                         DTC_PORT_COLOR_DAT); // [R16]
  end

  // htotal+5 wraps in 8 bits only if software programs above 250
  assign htotal_ext = s_q.regs.htotal + 8'(DTC_HTOTAL_ADD); // [R19]
  assign vtot       = dtc_vtotal(s_q.regs); // [R10] [R11]
  assign line_end   = (s_q.hcount == htotal_ext - 8'h01);
  assign frame_end  = (s_q.vcount == vtot + 10'(DTC_VTOTAL_ADD) - 10'h001);

  dtc_skew u_de_skew (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_sig   (s_q.de_raw),
    .i_sel   (s_q.regs.hbend[6:5]),
    .o_sig   (de_skewed)
  );

  dtc_skew u_hr_skew (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_sig   (s_q.hretr),
    .i_sel   (s_q.regs.hrend[6:5]),
    .o_sig   (hr_skewed)
  );

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    // host port
    if (i_bus.wr && idx_hit) begin
      s_d.index = i_bus.wdata[DTC_IDX_W-1:0]; // [R17]
    end
    if (i_bus.wr && dat_hit) begin
      unique case (s_q.index) // [R16]
        DTC_IDX_HTOTAL:  s_d.regs.htotal  = i_bus.wdata;
        DTC_IDX_HDEND:   s_d.regs.hdend   = i_bus.wdata;
        DTC_IDX_HBSTART: s_d.regs.hbstart = i_bus.wdata;
        DTC_IDX_HBEND:   s_d.regs.hbend   = i_bus.wdata; // [R1]
        DTC_IDX_HRSTART: s_d.regs.hrstart = i_bus.wdata;
        DTC_IDX_HREND:   s_d.regs.hrend   = i_bus.wdata;
        DTC_IDX_VTOTAL:  s_d.regs.vtotal  = i_bus.wdata;
        DTC_IDX_VHIGH:   s_d.regs.vhigh   = i_bus.wdata; // [R11]
        DTC_IDX_PRESET:  s_d.regs.preset  = i_bus.wdata;
        DTC_IDX_MAXSCAN: s_d.regs.maxscan = i_bus.wdata;
        default: ;
      endcase
    end
    if (i_bus.rd) begin
      s_d.rvalid = idx_hit | dat_hit;
      s_d.rdata  = DTC_RST_ZERO;
      if (idx_hit) begin
        s_d.rdata = {3'h0, s_q.index};
      end else if (dat_hit) begin
        unique case (s_q.index) // [R16]
          DTC_IDX_HTOTAL:  s_d.rdata = s_q.regs.htotal;
          DTC_IDX_HDEND:   s_d.rdata = s_q.regs.hdend;
          DTC_IDX_HBSTART: s_d.rdata = s_q.regs.hbstart;
          DTC_IDX_HBEND:   s_d.rdata = s_q.regs.hbend;
          DTC_IDX_HRSTART: s_d.rdata = s_q.regs.hrstart;
          DTC_IDX_HREND:   s_d.rdata = s_q.regs.hrend;
          DTC_IDX_VTOTAL:  s_d.rdata = s_q.regs.vtotal;
          DTC_IDX_VHIGH:   s_d.rdata = s_q.regs.vhigh;
          DTC_IDX_PRESET:  s_d.rdata = s_q.regs.preset;
          DTC_IDX_MAXSCAN: s_d.rdata = s_q.regs.maxscan;
          default:         s_d.rdata = DTC_RST_ZERO;
        endcase
      end
    end

    // horizontal character counter, one step per character clock
    if (line_end) begin
      s_d.hcount = '0; // [R19]
    end else begin
      s_d.hcount = s_q.hcount + 8'h01;
    end
    s_d.de_raw = (s_q.hcount <= s_q.regs.hdend);

    // end compare placed after start so a same-count match ends the pulse
    if (s_q.hcount == s_q.regs.hbstart) begin
      s_d.hblank = 1'b1; // [R18]
    end
    if (s_q.hcount[5:0] == dtc_hb_end(s_q.regs)) begin
      s_d.hblank = 1'b0; // [R3] [R4]
    end
    if (s_q.hcount == s_q.regs.hrstart) begin
      s_d.hretr = 1'b1; // [R6]
    end
    if (s_q.hcount[4:0] == s_q.regs.hrend[4:0]) begin
      s_d.hretr = 1'b0; // [R7]
    end

    // vertical line counter and row scan, stepped once per line
    if (line_end) begin
      if (frame_end) begin
        s_d.vcount = '0; // [R10]
        s_d.row    = s_q.regs.preset[4:0]; // [R12]
      end else begin
        s_d.vcount = s_q.vcount + 10'h001;
        if (s_q.row == s_q.regs.maxscan[4:0]) begin
          s_d.row = '0; // [R13]
        end else begin
          s_d.row = s_q.row + 5'h01; // [R13]
        end
      end
    end
    // vertical retrace spans the last line of the frame only here; the
    // retrace start/end registers live outside this block
    s_d.vretr = frame_end;

    s_d.video.hblank   = s_q.hblank; // [R20]
    s_d.video.hretrace = hr_skewed; // [R8]
    s_d.video.vretrace = s_q.vretr;
    s_d.video.disp_en  = de_skewed & ~s_q.vretr; // [R2]
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q              <= '0;
      s_q.regs.htotal  <= DTC_RST_HTOTAL;
      s_q.regs.hdend   <= DTC_RST_HDEND;
      s_q.regs.hbstart <= DTC_RST_HBSTART;
      s_q.regs.hbend   <= DTC_RST_HBEND;
      s_q.regs.hrstart <= DTC_RST_HRSTART;
      s_q.regs.hrend   <= DTC_RST_HREND;
      s_q.regs.vtotal  <= DTC_RST_VTOTAL;
      s_q.regs.vhigh   <= DTC_RST_VHIGH;
      s_q.regs.maxscan <= DTC_RST_MAXSCAN;
    end else begin
      s_q <= s_d;
    end
  end

  // row scan line counter and panning extension are registered state
  always_comb begin
    o_rdata         = s_q.rdata;
    o_rvalid        = s_q.rvalid;
    o_video         = s_q.video;
    o_scan.row_scan = s_q.row;
    o_scan.byte_pan = s_q.regs.preset[6:5]; // [R14]
    o_scan.line     = s_q.vcount;
  end

  // video timing checks
  a_hblank_start: assert property ( // [R18]
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_q.hcount == s_q.regs.hbstart &&
     s_q.hcount[5:0] != dtc_hb_end(s_q.regs)) |=> s_q.hblank)
    else $error("blank did not start");

  a_hblank_end: assert property ( // [R3]
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_q.hcount[5:0] == dtc_hb_end(s_q.regs)) |=> !s_q.hblank ##1
    !o_video.hblank)
    else $error("blank did not end");

  a_hblank_out: assert property ( // [R20]
    @(posedge i_clock) disable iff (!i_rst_n)
    1'b1 |=> o_video.hblank == $past(s_q.hblank))
    else $error("blank output not registered");

  a_hretr_start: assert property ( // [R6]
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_q.hcount == s_q.regs.hrstart &&
     s_q.hcount[4:0] != s_q.regs.hrend[4:0]) |=> s_q.hretr)
    else $error("retrace did not start");

  a_hretr_end: assert property ( // [R7]
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_q.hcount[4:0] == s_q.regs.hrend[4:0]) |=> !s_q.hretr)
    else $error("retrace did not end");

  a_hretr_noskew: assert property ( // [R8]
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_q.regs.hrend[6:5] == 2'h0) |=>
    o_video.hretrace == $past(s_q.hretr))
    else $error("retrace skew wrong");

  a_de_noskew: assert property ( // [R2]
    @(posedge i_clock) disable iff (!i_rst_n)
    (s_q.regs.hbend[6:5] == 2'h0) |=>
    o_video.disp_en == $past(s_q.de_raw && !s_q.vretr))
    else $error("display enable skew wrong");

  a_de_vmask: assert property ( // [R2]
    @(posedge i_clock) disable iff (!i_rst_n)
    s_q.vretr |=> !o_video.disp_en)
    else $error("display enable during retrace");

  a_line_wrap: assert property ( // [R19]
    @(posedge i_clock) disable iff (!i_rst_n)
    line_end |=> s_q.hcount == 8'h00)
    else $error("line length wrong");

  a_frame_wrap: assert property ( // [R10]
    @(posedge i_clock) disable iff (!i_rst_n)
    (line_end && frame_end) |=> s_q.vcount == 10'h000)
    else $error("frame length wrong");

  a_row_preset: assert property ( // [R12]
    @(posedge i_clock) disable iff (!i_rst_n)
    (line_end && frame_end) |=>
    s_q.row == $past(s_q.regs.preset[4:0]))
    else $error("row preset not loaded");

  a_row_clear: assert property ( // [R13]
    @(posedge i_clock) disable iff (!i_rst_n)
    (line_end && !frame_end && s_q.row == s_q.regs.maxscan[4:0])
    |=> s_q.row == 5'h00)
    else $error("row not cleared");

  a_row_step: assert property ( // [R13]
    @(posedge i_clock) disable iff (!i_rst_n)
    (line_end && !frame_end && s_q.row != s_q.regs.maxscan[4:0])
    |=> s_q.row == $past(s_q.row) + 5'h01)
    else $error("row did not advance");

  // host port checks
  a_reg_write: assert property ( // [R16]
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_bus.wr && dat_hit && s_q.index == DTC_IDX_HBEND)
    |=> s_q.regs.hbend == $past(i_bus.wdata))
    else $error("register write lost");

  a_regs_hold: assert property ( // [R16]
    @(posedge i_clock) disable iff (!i_rst_n)
    !(i_bus.wr && dat_hit) |=> $stable(s_q.regs))
    else $error("register changed without write");

  a_index_mask: assert property ( // [R17]
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_bus.wr && idx_hit) |=>
    s_q.index == $past(i_bus.wdata[4:0]))
    else $error("index not taken from low bits");

  a_read_valid: assert property ( // [R16]
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_bus.rd && (idx_hit || dat_hit)) |=> o_rvalid)
    else $error("read not answered");

  a_read_refuse: assert property ( // [R17]
    @(posedge i_clock) disable iff (!i_rst_n)
    (i_bus.rd && !idx_hit && !dat_hit) |=> !o_rvalid)
    else $error("foreign port answered");
endmodule
`default_nettype wire

// >>> tb/dtc_monitor.sv
// display monitor model: measures sync, blank and enable timing
`default_nettype none
module dtc_monitor (
  input  wire logic                i_clock,
  input  wire dtc_pkg::dtc_video_t i_video,
  output logic [15:0]              o_line,
  output logic [15:0]              o_hbw,
  output logic [15:0]              o_hrw,
  output logic [15:0]              o_hro,
  output logic [15:0]              o_deo,
  output logic [15:0]              o_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  import dtc_pkg::*;
  logic [15:0] cyc = '0;
  logic [15:0] t_hb = '0;
  logic [15:0] t_hr = '0;
  logic [15:0] t_vr = '0;
  dtc_video_t  pv = '0;
  // sampled on the falling edge so the registered levels have settled
  always @(negedge i_clock) begin
    cyc = cyc + 16'h0001;
    if (i_video.hblank && !pv.hblank)
      t_hb = cyc;
    if (!i_video.hblank && pv.hblank)
      o_hbw = cyc - t_hb;
    if (i_video.hretrace && !pv.hretrace) begin
      o_hro = cyc - t_hb;
      o_line = cyc - t_hr;
      t_hr = cyc;
    end
    if (!i_video.hretrace && pv.hretrace)
      o_hrw = cyc - t_hr;
    if (!i_video.disp_en && pv.disp_en)
      o_deo = cyc - t_hb;
    if (i_video.vretrace && !pv.vretrace) begin
      o_frame = cyc - t_vr;
      t_vr = cyc;
    end
    pv = i_video;
  end
endmodule
`default_nettype wire

// >>> tb/dtc_timing_tb.sv
// self-checking bench for the sync/blank timing block
`default_nettype none
module dtc_timing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dtc_pkg::*;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        color = 1'b1;
  dtc_bus_t    bus = '0;
  logic [7:0]  rdata;
  logic        rvalid;
  dtc_video_t  video;
  dtc_scan_t   scan;
  logic [15:0] line, hbw, hrw, hro, deo, frame, b_ro, b_de;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;

  dtc_timing u_dtc_timing (.i_clock(clock), .i_rst_n(rst_n),
    .i_color_sel(color), .i_bus(bus), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_video(video), .o_scan(scan));
  dtc_monitor u_dtc_monitor (.i_clock(clock), .i_video(video),
    .o_line(line), .o_hbw(hbw), .o_hrw(hrw), .o_hro(hro),
    .o_deo(deo), .o_frame(frame));

  initial begin
    forever #2.5 clock = ~clock;
  end
  // two frames of 17152 cycles plus register traffic fit well below
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors = num_errors + 1;
      end_sim();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // holds the strobe through its taking edge; caller releases via idle
  task automatic bus_op(input logic w, input logic [15:0] a,
                        input logic [7:0] d);
    bus.wr = w;
    bus.rd = !w;
    bus.addr = a;
    bus.wdata = d;
    @(posedge clock) #1;
  endtask
  task automatic idle();
    bus = '0;
    @(posedge clock) #1;
  endtask
  function automatic logic [15:0] port(input logic dat);
    return (color ? DTC_PORT_COLOR_IDX : DTC_PORT_MONO_IDX) + dat;
  endfunction
  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] d);
    bus_op(1'b1, port(1'b0), {3'h0, idx});
    bus_op(1'b1, port(1'b1), d);
    idle();
  endtask
  task automatic reg_rd(input logic [4:0] idx, input logic [7:0] exp);
    bus_op(1'b1, port(1'b0), {3'h0, idx});
    bus_op(1'b0, port(1'b1), 8'h00);
    chk(rvalid, 1'b1);
    chk(rdata, exp);
    idle();
  endtask
  task automatic lines(input int n);
    repeat (n) @(posedge video.hretrace);
    @(posedge clock) #1;
  endtask

  task automatic t_reset();
    logic [7:0] rv [6] = '{8'h80, 8'h55, 8'h81, 8'hbf, 8'h1f, 8'h00};
    for (int i = 0; i < 6; i++) begin
      reg_rd(DTC_IDX_HBEND + 5'(i), rv[i]);
    end
    // upper bits of the index byte must be dropped
    bus_op(1'b1, port(1'b0), 8'he8);
    bus_op(1'b0, port(1'b0), 8'h00);
    chk(rdata, 8'h08);
    idle();
    $display("test reset values done");
  endtask

  task automatic t_ports();
    color = 1'b0;
    for (int i = 0; i < 6; i++) begin
      reg_wr(DTC_IDX_HBEND + 5'(i), 8'ha5 ^ 8'(i));
      reg_rd(DTC_IDX_HBEND + 5'(i), 8'ha5 ^ 8'(i));
    end
    reg_wr(5'h0a, 8'h77);
    reg_rd(5'h0a, 8'h00);
    bus_op(1'b0, DTC_PORT_COLOR_DAT, 8'h00);
    chk(rvalid, 1'b0);
    idle();
    $display("test port decode done");
  endtask

  task automatic t_horiz();
    reg_wr(DTC_IDX_HTOTAL, 8'h3b);
    reg_wr(DTC_IDX_HDEND, 8'h23);
    reg_wr(DTC_IDX_HBSTART, 8'h24);
    reg_wr(DTC_IDX_HRSTART, 8'h26);
    // end blank 0x2a needs its sixth bit from the end-retrace register
    for (int k = 0; k < 4; k++) begin
      reg_wr(DTC_IDX_HBEND, 8'h8a | 8'(k << 5));
      reg_wr(DTC_IDX_HREND, 8'h89 | 8'(k << 5));
      lines(4);
      if (k == 0) begin
        b_ro = hro;
        b_de = deo;
      end
      chk(line, 16'd64);
      chk(hbw, 16'd6);
      chk(hrw, 16'd3);
      chk(hro - b_ro, 16'(k));
      chk(deo - b_de, 16'(k));
    end
    $display("test horizontal timing done");
  endtask

  task automatic t_vert();
    logic [4:0] rows [3] = '{5'h03, 5'h04, 5'h00};
    reg_wr(DTC_IDX_VTOTAL, 8'h0a);
    reg_wr(DTC_IDX_VHIGH, 8'h01);
    reg_wr(DTC_IDX_MAXSCAN, 8'h04);
    reg_wr(DTC_IDX_PRESET, 8'h63);
    repeat (2) @(posedge video.vretrace);
    repeat (2) @(posedge clock);
    chk(frame, 16'd17152);
    chk(scan.byte_pan, 2'b11);
    @(negedge video.vretrace);
    for (int i = 0; i < 3; i++) begin
      @(posedge video.hblank);
      #1;
      chk(scan.row_scan, rows[i]);
      chk(scan.line, 16'(i));
    end
    reg_wr(DTC_IDX_PRESET, 8'h03);
    chk(scan.byte_pan, 2'b00);
    $display("test vertical and row scan done");
  endtask

  initial begin
    repeat (20) @(posedge clock);
    #1 rst_n = 1'b1;
    @(posedge clock) #1;
    t_reset();
    t_ports();
    t_horiz();
    t_vert();
    end_sim();
  end
endmodule
`default_nettype wire
